// file: card_operating_conditions.sv
// Card operating-conditions register and power-up sequencing.
// Assumes MCLK at 250 MHz, BUS_CLK from the host, open-drain command line
// resolved outside from CMD_OUT and CMD_OE_N.
//
// What this block does
// - Command line values are captured only on the rising edge of the bus clock.
// - The card works at any transfer clock from stopped up to its rated maximum.
// - Each card register is reachable only through its own dedicated command.
// - Bit 31 of the 32-bit operating-conditions value is low until power-up completes.
// - Bits 23:15 read ones, bit 7 reads one only on dual-voltage cards, other bits zero.
// - The busy bit combines as a wired-AND across cards on the command line.
// - After power-up the card sits idle and answers only negotiation commands until one arrives whose argument shares a set bit with bits 23:7 of the value.
// - Initialization finishes within one second of the first valid negotiation command.
`timescale 1ns/1ps
`default_nettype none
`include "card_opcond_defs.svh"

module card_operating_conditions
   import card_opcond_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = `POWERUP_DONE_MS * `MCLK_MHZ * 1000,
   parameter bit          DUAL_VOLTAGE   = 1'b0
)
(
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        BUS_CLK,
   input  wire logic        CMD_IN,
   output var  logic        CMD_OUT,
   output var  logic        CMD_OE_N,
   output var  logic [31:0] OPERATING_CONDITIONS,
   output var  logic        CARD_READY,
   output var  logic        IDLE_STATE,
   output var  logic        ACCESS_STROBE,
   output var  logic [2:0]  ACCESS_TARGET
);

   // ==========================================================
   // Derived timing
   localparam int unsigned LIMIT_CYCLES = `POWERUP_TIME_MS * `MCLK_MHZ * 1000;
   localparam int unsigned DONE_CYCLES  = (POWERUP_CYCLES < LIMIT_CYCLES) ? POWERUP_CYCLES : LIMIT_CYCLES;

   // ==========================================================
   // Register target decode
   function automatic logic [2:0] target_of(input logic [5:0] idx);
      if (idx == `CMD_INDEX_NEGOTIATE) begin
         target_of = 3'h1;
      end else if (idx == `CMD_INDEX_ID) begin
         target_of = 3'h2;
      end else if (idx == `CMD_INDEX_SPECIFIC) begin
         target_of = 3'h3;
      end else if (idx == `CMD_INDEX_EXTENDED) begin
         target_of = 3'h4;
      end else if (idx == `CMD_INDEX_ADDRESS) begin
         target_of = 3'h5;
      end else if (idx == `CMD_INDEX_DRIVER) begin
         target_of = 3'h6;
      end else begin
         target_of = 3'h0;
      end
   endfunction

   // ==========================================================
   // Link side
   logic        rst_link_n;
   logic [31:0] opc_link;
   logic        link_toggle;
   logic [5:0]  link_index;
   logic [31:0] link_arg;
   logic        cmd_o;
   logic        cmd_oe_n;
   logic [1:0]  rst_link_sync;
   logic [1:0]  busy_sync;

   always_ff @(posedge BUS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_link_sync <= 2'b00;
      end else begin
         rst_link_sync <= {rst_link_sync[0], 1'b1};
      end
   end
   assign rst_link_n = rst_link_sync[1];

   typedef struct packed {
      pu_state_t   pu;
      logic [31:0] cnt;
      logic [2:0]  tog_sync;
      logic [31:0] opc;
      logic        cmd_out;
      logic        cmd_oe_n;
      logic        strobe;
      logic [2:0]  target;
   } core_t;

   core_t q;
   core_t d;

   always_ff @(posedge BUS_CLK or negedge rst_link_n) begin
      if (!rst_link_n) begin
         busy_sync <= 2'b00;
      end else begin
         busy_sync <= {busy_sync[0], q.opc[`OPC_BUSY_BIT]};
      end
   end

   // Fixed window bits are constant; only the busy bit crosses
   assign opc_link = {busy_sync[1], q.opc[30:0]};

   card_cmd_link u_link (
      .bus_clk    (BUS_CLK),
      .rst_n      (rst_link_n),
      .cmd_i      (CMD_IN),
      .cmd_o      (cmd_o),
      .cmd_oe_n   (cmd_oe_n),
      .opc_value  (opc_link),
      .cmd_toggle (link_toggle),
      .cmd_index  (link_index),
      .cmd_arg    (link_arg)
   );

   // ==========================================================
   // Core side
   logic [1:0] oe_sync;
   logic [1:0] out_sync;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         oe_sync  <= 2'b11;
         out_sync <= 2'b11;
      end else begin
         oe_sync  <= {oe_sync[0], cmd_oe_n};
         out_sync <= {out_sync[0], cmd_o};
      end
   end

   logic        new_cmd;
   logic [2:0]  tgt;
   logic        valid_range;
   logic [31:0] fixed_opc;

   always_comb begin
      fixed_opc = `OPC_RESET_VALUE;
      fixed_opc[`OPC_WINDOW_HI:`OPC_WINDOW_LO] = `OPC_WINDOW_ONES;
      fixed_opc[`OPC_DUAL_BIT]                 = DUAL_VOLTAGE;
   end

   always_comb begin
      d           = q;
      d.tog_sync  = {q.tog_sync[1:0], link_toggle};
      new_cmd     = q.tog_sync[2] ^ q.tog_sync[1];
      tgt         = target_of(link_index);
      valid_range = |(link_arg[23:7] & fixed_opc[23:7]);
      d.strobe    = 1'b0;
      d.cmd_out   = out_sync[1];
      d.cmd_oe_n  = oe_sync[1];
      d.opc       = {q.opc[`OPC_BUSY_BIT], fixed_opc[30:0]};
      case (q.pu)
         PU_IDLE: begin
            if (new_cmd && tgt == 3'h1 && valid_range) begin
               d.cnt = 32'h0;
               d.pu  = PU_BUSY;
            end
         end
         PU_BUSY: begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt >= DONE_CYCLES - 1) begin
               d.pu                  = PU_READY;
               d.opc[`OPC_BUSY_BIT]  = 1'b1;
            end
         end
         PU_READY: begin
            if (new_cmd && tgt != 3'h0) begin
               d.strobe = 1'b1;
               d.target = tgt;
            end
         end
         default: d.pu = PU_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '{PU_IDLE, 32'h0, 3'b000, `OPC_RESET_VALUE, 1'b1, 1'b1, 1'b0, 3'h0};
      end else begin
         q <= d;
      end
   end

   assign CMD_OUT              = cmd_o;
   assign CMD_OE_N             = cmd_oe_n;
   assign OPERATING_CONDITIONS = q.opc;
   assign CARD_READY           = q.opc[`OPC_BUSY_BIT];
   assign IDLE_STATE           = q.pu[0];
   assign ACCESS_STROBE        = q.strobe;
   assign ACCESS_TARGET        = q.target;

endmodule

`default_nettype wire

// file: card_opcond_defs.svh
// Constants for the card operating-conditions block.
// Assumes inclusion by the package and by the design modules only.
`ifndef CARD_OPCOND_DEFS_SVH
`define CARD_OPCOND_DEFS_SVH

// ==========================================================
// Operating-conditions register layout
`define OPC_BUSY_BIT        31
`define OPC_WINDOW_HI       23
`define OPC_WINDOW_LO       15
`define OPC_WINDOW_ONES     9'h1FF
`define OPC_DUAL_BIT        7
`define OPC_RESET_VALUE     32'h00000000

// ==========================================================
// Command frame: start, direction, 6-bit index, 32-bit argument, crc7, end
`define CMD_FRAME_BITS      48
`define CMD_INDEX_NEGOTIATE 6'h01
`define CMD_INDEX_ID        6'h02
`define CMD_INDEX_SPECIFIC  6'h09
`define CMD_INDEX_EXTENDED  6'h08
`define CMD_INDEX_ADDRESS   6'h03
`define CMD_INDEX_DRIVER    6'h04
`define RSP_FRAME_BITS      48
`define RSP_RESERVED_IDX    6'h3F
`define RSP_RESERVED_CRC    7'h7F

// ==========================================================
// Timing
`define POWERUP_TIME_MS     1000
`define MCLK_MHZ            250
`define POWERUP_DONE_MS     1
`define NCR_CYCLES          2

`endif

// file: card_opcond_pkg.sv
// Types for the card operating-conditions block.
// Assumes the constants header is in the include path.
`include "card_opcond_defs.svh"

package card_opcond_pkg;

   typedef enum logic [3:0] {
      LNK_IDLE = 4'h1,
      LNK_RECV = 4'h2,
      LNK_WAIT = 4'h4,
      LNK_SEND = 4'h8
   } link_state_t;

   typedef enum logic [2:0] {
      PU_IDLE  = 3'h1,
      PU_BUSY  = 3'h2,
      PU_READY = 3'h4
   } pu_state_t;

endpackage

// file: card_cmd_link.sv
// Command-line engine on the card bus clock: receives command frames,
// sends the operating-conditions response open-drain.
// Assumes BUS_CLK is the host bus clock, which may stop between frames.
`timescale 1ns/1ps
`default_nettype none
`include "card_opcond_defs.svh"

module card_cmd_link
   import card_opcond_pkg::*;
(
   input  wire logic        bus_clk,
   input  wire logic        rst_n,
   input  wire logic        cmd_i,
   output var  logic        cmd_o,
   output var  logic        cmd_oe_n,
   input  wire logic [31:0] opc_value,
   output var  logic        cmd_toggle,
   output var  logic [5:0]  cmd_index,
   output var  logic [31:0] cmd_arg
);

   typedef struct packed {
      link_state_t state;
      logic [5:0]  cnt;
      logic [47:0] shift;
      logic        toggle;
      logic [5:0]  index;
      logic [31:0] arg;
      logic        out;
      logic        oe_n;
   } link_t;

   link_t q;
   link_t d;

   always_comb begin
      d = q;
      case (q.state)
         LNK_IDLE: begin
            d.oe_n = 1'b1;
            d.out  = 1'b1;
            if (!cmd_i) begin
               d.shift = {47'h0, cmd_i};
               d.cnt   = 6'd1;
               d.state = LNK_RECV;
            end
         end
         LNK_RECV: begin
            d.shift = {q.shift[46:0], cmd_i};
            d.cnt   = q.cnt + 6'd1;
            if (q.cnt == 6'(`CMD_FRAME_BITS - 1)) begin
               d.index  = d.shift[45:40];
               d.arg    = d.shift[39:8];
               d.toggle = ~q.toggle;
               d.cnt    = 6'd0;
               if (d.shift[45:40] == `CMD_INDEX_NEGOTIATE && d.shift[46]) begin
                  d.state = LNK_WAIT;
               end else begin
                  d.state = LNK_IDLE;
               end
            end
         end
         LNK_WAIT: begin
            d.cnt = q.cnt + 6'd1;
            if (q.cnt == 6'(`NCR_CYCLES - 1)) begin
               d.shift = {2'b00, `RSP_RESERVED_IDX, opc_value, `RSP_RESERVED_CRC, 1'b1};
               d.cnt   = 6'd0;
               d.state = LNK_SEND;
            end
         end
         LNK_SEND: begin
            d.oe_n  = q.shift[47];
            d.out   = q.shift[47];
            d.shift = {q.shift[46:0], 1'b1};
            d.cnt   = q.cnt + 6'd1;
            if (q.cnt == 6'(`RSP_FRAME_BITS)) begin
               d.oe_n  = 1'b1;
               d.out   = 1'b1;
               d.state = LNK_IDLE;
            end
         end
         default: d.state = LNK_IDLE;
      endcase
   end

   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{LNK_IDLE, 6'h00, 48'h0, 1'b0, 6'h00, 32'h0, 1'b1, 1'b1};
      end else begin
         q <= d;
      end
   end

   assign cmd_o      = q.out;
   assign cmd_oe_n   = q.oe_n;
   assign cmd_toggle = q.toggle;
   assign cmd_index  = q.index;
   assign cmd_arg    = q.arg;

endmodule

`default_nettype wire

// file: card_opcond_assertions.sv
// Checker for the operating-conditions block.
// Assumes it is bound onto card_operating_conditions.
`timescale 1ns/1ps
`default_nettype none
module card_opcond_assertions #(
   parameter int unsigned POWERUP_CYCLES = 20,
   parameter bit          DUAL_VOLTAGE   = 1'b0
)(
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        BUS_CLK,
   input wire logic        CMD_IN,
   input wire logic        CMD_OUT,
   input wire logic        CMD_OE_N,
   input wire logic [31:0] OPERATING_CONDITIONS,
   input wire logic        CARD_READY,
   input wire logic        IDLE_STATE,
   input wire logic        ACCESS_STROBE,
   input wire logic [2:0]  ACCESS_TARGET
);
   logic [31:0] busy_cnt_q;
   // ======
   // Power-up cycle count
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_cnt_q <= 32'h0;
      end else if (!IDLE_STATE && !CARD_READY) begin
         busy_cnt_q <= busy_cnt_q + 32'h1;
      end
   end
   // ======
   // Properties
   AST_WINDOW: assert property (@(posedge MCLK) disable iff (!RST_N)
      $past(RST_N) |-> OPERATING_CONDITIONS[30:0] == {7'h00, 9'h1FF, 7'h00, DUAL_VOLTAGE, 7'h00}) else $error("window");
   AST_READY_MIRROR: assert property (@(posedge MCLK) disable iff (!RST_N)
      CARD_READY == OPERATING_CONDITIONS[31]) else $error("ready mirror");
   AST_READY_STICKY: assert property (@(posedge MCLK) disable iff (!RST_N)
      OPERATING_CONDITIONS[31] |=> OPERATING_CONDITIONS[31]) else $error("ready dropped");
   AST_IDLE_BUSY: assert property (@(posedge MCLK) disable iff (!RST_N)
      IDLE_STATE |-> !CARD_READY) else $error("ready while idle");
   AST_STROBE_READY: assert property (@(posedge MCLK) disable iff (!RST_N)
      ACCESS_STROBE |-> CARD_READY && !IDLE_STATE) else $error("early strobe");
   AST_STROBE_PULSE: assert property (@(posedge MCLK) disable iff (!RST_N)
      ACCESS_STROBE |=> !ACCESS_STROBE) else $error("long strobe");
   AST_TARGET: assert property (@(posedge MCLK) disable iff (!RST_N)
      ACCESS_STROBE |-> ACCESS_TARGET inside {[3'h1:3'h6]}) else $error("target");
   AST_TARGET_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)
      !ACCESS_STROBE |-> $stable(ACCESS_TARGET)) else $error("target moved");
   AST_INIT_BOUND: assert property (@(posedge MCLK) disable iff (!RST_N)
      busy_cnt_q <= POWERUP_CYCLES + 8) else $error("init too long");
   AST_READY_CAUSE: assert property (@(posedge MCLK) disable iff (!RST_N)
      $rose(CARD_READY) |-> busy_cnt_q + 2 >= POWERUP_CYCLES) else $error("init too short");
   AST_OPEN_DRAIN: assert property (@(posedge BUS_CLK) disable iff (!RST_N)
      CMD_OUT == CMD_OE_N) else $error("line drive");
endmodule
bind card_operating_conditions card_opcond_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES),
   .DUAL_VOLTAGE(DUAL_VOLTAGE)) chk_u (.MCLK, .RST_N, .BUS_CLK, .CMD_IN, .CMD_OUT, .CMD_OE_N,
   .OPERATING_CONDITIONS, .CARD_READY, .IDLE_STATE, .ACCESS_STROBE, .ACCESS_TARGET);
`default_nettype wire

// file: card_host_model.sv
// Host model: clocks the bus only inside its tasks (frames, trailing cycles, tick), sends commands.
// Assumes the bench resolves the pulled-up command line.
`timescale 1ns/1ps
`default_nettype none
module card_host_model (
   output var  logic bus_clk,
   output var  logic cmd_drv,
   input  wire logic cmd_line
);
   initial begin
      bus_clk = 1'b0;
      cmd_drv = 1'b1;
   end
   // ======
   // Clocking
   // 80 ns period
   // one fixed bench rate
   // The card logic does not depend on the rate, so identification frames
   // share the 80 ns period with transfer frames in this bench.
   task automatic tick();
      #40 bus_clk = 1'b1;
      #40 bus_clk = 1'b0;
   endtask
   // ======
   // Frames
   // drive after fall, sample at rise
   task automatic send(input logic [5:0] idx, input logic [31:0] arg, input bit want,
                       output logic [47:0] rsp);
      logic [47:0] frm;
      int          n;
      frm = {2'b01, idx, arg, 7'h7F, 1'b1};
      rsp = '1;
      n = 0;
      for (int i = 47; i >= 0; i--) begin
         cmd_drv = frm[i];
         tick();
      end
      cmd_drv = 1'b1;
      for (int k = 0; k < (want ? 60 : 4); k++) begin
         #40;
         if ((n > 0 && n < 48) || (n == 0 && cmd_line === 1'b0)) begin
            rsp = {rsp[46:0], cmd_line};
            n++;
         end
         bus_clk = 1'b1;
         #40 bus_clk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: tb.sv
// Bench for the operating-conditions block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [31:0] WIN = 32'h00FF8000;
   localparam logic [5:0]  IDX [6] = '{6'h01, 6'h02, 6'h09, 6'h08, 6'h03, 6'h04};
   logic        MCLK, RST_N, bus_clk, cmd_drv, cmd_out, cmd_oe_n, ready, idle, strobe;
   logic [31:0] opc;
   logic [2:0]  tgt, last_tgt;
   logic [47:0] rsp;
   wire  logic  cmd_line;
   int          fails = 0, cmp_count = 0, strobes = 0;
   assign cmd_line = cmd_drv & (cmd_oe_n | cmd_out);
   card_host_model host_u (.bus_clk(bus_clk), .cmd_drv(cmd_drv), .cmd_line(cmd_line));
   card_operating_conditions #(.POWERUP_CYCLES(20), .DUAL_VOLTAGE(1'b0)) dut_u (
      .MCLK(MCLK), .RST_N(RST_N), .BUS_CLK(bus_clk), .CMD_IN(cmd_line), .CMD_OUT(cmd_out),
      .CMD_OE_N(cmd_oe_n), .OPERATING_CONDITIONS(opc), .CARD_READY(ready), .IDLE_STATE(idle),
      .ACCESS_STROBE(strobe), .ACCESS_TARGET(tgt));
   initial MCLK = 1'b0;
   always #2 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      if (strobe === 1'b1) begin
         strobes <= strobes + 1;
         last_tgt <= tgt;
      end
   end
   function automatic logic [47:0] rsp_of(input logic [31:0] v);
      return {2'b00, 6'h3F, v, 7'h7F, 1'b1};
   endfunction
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_idle();
      chk("opc_reset", opc, WIN);
      chk("ready_reset", ready, 0);
      host_u.send(6'h02, WIN, 1'b0, rsp);
      chk("strobe_idle", 48'(strobes), 0);
      host_u.send(6'h01, 32'h0, 1'b1, rsp);
      chk("rsp_idle", rsp, rsp_of(WIN));
      chk("still_idle", idle, 1);
      $display("t_idle done");
   endtask
   task automatic t_power();
      int n;
      host_u.send(6'h01, WIN, 1'b1, rsp);
      chk("rsp_first", rsp & ~(48'h1 << 39), rsp_of(WIN));
      chk("idle_left", idle, 0);
      for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge MCLK);
      if (n == 200) begin
         fails++;
         give_verdict();
      end
      chk("opc_ready", opc, 32'h80FF8000);
      $display("t_power done");
   endtask
   task automatic t_access();
      int s;
      for (int i = 0; i < 7; i++) begin
         s = strobes;
         host_u.send(i < 6 ? IDX[i] : 6'h05, WIN, i == 0, rsp);
         chk("strobes", 48'(strobes - s), i < 6);
         if (i < 6) chk("target", last_tgt, i + 1);
         if (i == 0) chk("rsp_ready", rsp, rsp_of(32'h80FF8000));
      end
      $display("t_access done");
   endtask
   initial begin
      RST_N = 1'b0;
      repeat (4) @(posedge MCLK);
      repeat (2) host_u.tick();
      @(negedge MCLK) RST_N = 1'b1;
      repeat (4) host_u.tick();
      t_idle();
      t_power();
      t_access();
      give_verdict();
   end
endmodule
`default_nettype wire
